// ===== src/sfdp_defs.vh
// Byte offsets, field positions and table values of the discoverable-parameter store.
`ifndef SFDP_DEFS_VH
`define SFDP_DEFS_VH

// ----------------------------------------------------------------
// APB register map (byte addresses)
// ----------------------------------------------------------------
`define SFDP_ADDR_W 8
// Words 30h..54h mirror the table at their printed byte offsets.
`define SFDP_TBL_FIRST 8'h30
`define SFDP_TBL_LAST 8'h54
`define SFDP_W34_ADDR 8'h34
`define SFDP_W38_ADDR 8'h38
`define SFDP_W3C_ADDR 8'h3C
`define SFDP_W40_ADDR 8'h40
`define SFDP_W44_ADDR 8'h44
`define SFDP_W48_ADDR 8'h48
`define SFDP_W4C_ADDR 8'h4C
`define SFDP_W50_ADDR 8'h50
// Header word holding the basic-table pointer.
`define SFDP_HDR_PTR_ADDR 8'h0C
// Control word: bit 0 selects the large-block variant.
`define SFDP_CTRL_ADDR 8'hF0
// Status word: bit 0 shows the variant in force, bits 15:8 the last table offset read.
`define SFDP_STAT_ADDR 8'hF4
`define SFDP_CTRL_RESET 1'b0

// ----------------------------------------------------------------
// Header pointer
// ----------------------------------------------------------------
`define SFDP_PTR_VALUE 24'h000030
`define SFDP_PTR_ID_MSB 8'hFF

// ----------------------------------------------------------------
// Byte 30h..33h fields
// ----------------------------------------------------------------
`define SFDP_MIN_ERASE 2'b01
`define SFDP_WR_GRAN 1'b1
`define SFDP_VOL_BP 1'b0
`define SFDP_WREN_SEL 1'b0
`define SFDP_ERASE4K_OP 8'h20
`define SFDP_ADDR_BYTES 2'b01

// ----------------------------------------------------------------
// Density and fast-read descriptors
// ----------------------------------------------------------------
`define SFDP_DENSITY 32'h1FFFFFFF
`define SFDP_144_WAIT 5'b00100
`define SFDP_144_MODE 3'b010
`define SFDP_144_OP 8'hEB
`define SFDP_114_WAIT 5'b01000
`define SFDP_114_MODE 3'b000
`define SFDP_114_OP 8'h6B
`define SFDP_112_WAIT 5'b01000
`define SFDP_112_MODE 3'b000
`define SFDP_112_OP 8'h3B
`define SFDP_122_WAIT 5'b00000
`define SFDP_122_MODE 3'b100
`define SFDP_122_OP 8'hBB
`define SFDP_222_OP 8'hFF
`define SFDP_444_WAIT 5'b00100
`define SFDP_444_MODE 3'b010
`define SFDP_444_OP 8'hEB

// ----------------------------------------------------------------
// Erase types and times
// ----------------------------------------------------------------
`define SFDP_ET1_SIZE 8'h0C
`define SFDP_ET1_OP 8'h20
`define SFDP_ET2_SIZE 8'h0F
`define SFDP_ET2_OP 8'h52
`define SFDP_ET3_SIZE 8'h10
`define SFDP_ET3_OP 8'hD8
`define SFDP_ET4_SIZE_K 8'h12
`define SFDP_ET4_OP_K 8'hD8
`define SFDP_ET_NONE_SIZE 8'h00
`define SFDP_ET_NONE_OP 8'hFF
`define SFDP_ERASE_MULT 4'b0010
`define SFDP_ET1_TIME 5'b00110
`define SFDP_ET2_TIME 5'b01000
`define SFDP_ET3_TIME 5'b01010
`define SFDP_ET4_TIME_K 5'b00101
`define SFDP_TIME_UNIT 2'b01

`endif

// ===== src/sfdp_basic_param_rom.v
// Read-only discoverable-parameter store with an APB slave port.
//
// Operation
// - Byte 30h: erase size, granularity, top ones.
// - Byte 30h bits 3 and 4 read zero.
// - Address bytes 01b and double-edge bit set.
// - Fast read 1-1-2, 1-2-2, 1-4-4, 1-1-4 advertised.
// - Density bytes FFh FFh FFh 1Fh.
// - 1-4-4 wait 4, mode 2, opcode EBh.
// - 1-1-4 wait 8, no mode, opcode 6Bh.
// - 1-1-2 wait 8, no mode, opcode 3Bh.
// - 1-2-2 no wait, mode 4, opcode BBh.
// - 2-2-2 read unsupported, zero counts, FFh.
// - 4-4-4 supported, reserved bits read ones.
// - 4-4-4 wait 4, mode 2, opcode EBh.
// - Erase type 1: 4 KB, opcode 20h.
// - Erase type 2: 32 KB, opcode 52h.
// - Erase type 3 depends on block variant.
// - Erase type 4 depends on block variant.
// - Erase time multiplier reads 0010b.
// - Erase type 1 and 2 typical times.
// - Erase type 3 and 4 times per variant.
// - Parenthesised values only for large-block variant.
// - Header table pointer holds 30h.
`timescale 1ns/1ps
`include "sfdp_defs.vh"

module sfdp_basic_param_rom (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   output wire pready,
   output reg [31:0] prdata,
   output wire pslverr,
   output wire large_block_mode
);

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   // Every access finishes in its first access cycle; no wait states.
   wire setup = psel && !penable;
   wire access = psel && penable;
   wire [7:0] word_addr = {paddr[7:2], 2'b00};
   wire in_range = (paddr[31:8] == 24'h000000) && (paddr[1:0] == 2'b00);
   wire is_tbl = (word_addr >= `SFDP_TBL_FIRST) && (word_addr <= `SFDP_TBL_LAST);
   wire is_ptr = (word_addr == `SFDP_HDR_PTR_ADDR);
   wire is_ctrl = (word_addr == `SFDP_CTRL_ADDR);
   wire is_stat = (word_addr == `SFDP_STAT_ADDR);
   wire mapped = in_range && (is_tbl || is_ptr || is_ctrl || is_stat);
   // The table is read-only, so only the control word accepts writes.
   wire wr_ok = is_ctrl;
   reg err_q;
   reg large_q;
   reg [7:0] last_q;
   reg [31:0] rd_d;

   assign pready = access;
   assign pslverr = access && err_q;
   assign large_block_mode = large_q;

   // ----------------------------------------------------------------
   // Table words
   // ----------------------------------------------------------------
   always @* begin
      rd_d = 32'hFFFFFFFF;
      case (word_addr)
         `SFDP_HDR_PTR_ADDR: begin
            rd_d = {`SFDP_PTR_ID_MSB, `SFDP_PTR_VALUE};
         end
         `SFDP_TBL_FIRST: begin
            rd_d[31:24] = 8'hFF;
            rd_d[16] = 1'b1;
            rd_d[20] = 1'b1;
            rd_d[21] = 1'b1;
            rd_d[22] = 1'b1;
            rd_d[23] = 1'b1;
            rd_d[18:17] = `SFDP_ADDR_BYTES;
            rd_d[19] = 1'b1;
            rd_d[15:8] = `SFDP_ERASE4K_OP;
            rd_d[7:5] = 3'b111;
            rd_d[2] = `SFDP_WR_GRAN;
            rd_d[1:0] = `SFDP_MIN_ERASE;
            rd_d[4] = `SFDP_WREN_SEL;
            rd_d[3] = `SFDP_VOL_BP;
         end
         `SFDP_W34_ADDR: begin
            rd_d = `SFDP_DENSITY;
         end
         `SFDP_W38_ADDR: begin
            rd_d[31:16] = {`SFDP_114_OP, `SFDP_114_MODE, `SFDP_114_WAIT};
            rd_d[15:0] = {`SFDP_144_OP, `SFDP_144_MODE, `SFDP_144_WAIT};
         end
         `SFDP_W3C_ADDR: begin
            rd_d[31:16] = {`SFDP_122_OP, `SFDP_122_MODE, `SFDP_122_WAIT};
            rd_d[15:0] = {`SFDP_112_OP, `SFDP_112_MODE, `SFDP_112_WAIT};
         end
         `SFDP_W40_ADDR: begin
            rd_d[7:1] = 7'b1111111;
            rd_d[0] = 1'b0;
         end
         `SFDP_W44_ADDR: begin
            rd_d[31:16] = {`SFDP_222_OP, 3'b000, 5'b00000};
         end
         `SFDP_W48_ADDR: begin
            rd_d[31:16] = {`SFDP_444_OP, `SFDP_444_MODE, `SFDP_444_WAIT};
         end
         `SFDP_W4C_ADDR: begin
            rd_d[31:16] = {`SFDP_ET2_OP, `SFDP_ET2_SIZE};
            rd_d[15:0] = {`SFDP_ET1_OP, `SFDP_ET1_SIZE};
         end
         `SFDP_W50_ADDR: begin
            if (large_q) begin
               rd_d[15:0] = {`SFDP_ET_NONE_OP, `SFDP_ET_NONE_SIZE};
               rd_d[31:16] = {`SFDP_ET4_OP_K, `SFDP_ET4_SIZE_K};
            end else begin
               rd_d[15:0] = {`SFDP_ET3_OP, `SFDP_ET3_SIZE};
               rd_d[31:16] = {`SFDP_ET_NONE_OP, `SFDP_ET_NONE_SIZE};
            end
         end
         `SFDP_TBL_LAST: begin
            rd_d[3:0] = `SFDP_ERASE_MULT;
            rd_d[10:4] = {`SFDP_TIME_UNIT, `SFDP_ET1_TIME};
            rd_d[17:11] = {`SFDP_TIME_UNIT, `SFDP_ET2_TIME};
            if (large_q) begin
               rd_d[24:18] = 7'b0000000;
               rd_d[31:25] = {`SFDP_TIME_UNIT, `SFDP_ET4_TIME_K};
            end else begin
               rd_d[24:18] = {`SFDP_TIME_UNIT, `SFDP_ET3_TIME};
               rd_d[31:25] = 7'b0000000;
            end
         end
         `SFDP_CTRL_ADDR: begin
            rd_d = {31'h00000000, large_q};
         end
         `SFDP_STAT_ADDR: begin
            rd_d = {16'h0000, last_q, 7'h00, large_q};
         end
         default: begin
            rd_d = 32'hFFFFFFFF;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   // Read data and error are captured in the setup cycle, so both are
   // stable from flops for the whole access cycle.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
         err_q <= 1'b0;
         large_q <= `SFDP_CTRL_RESET;
         last_q <= 8'h00;
      end else begin
         if (setup) begin
            err_q <= !mapped || (pwrite && !wr_ok);
            if (mapped && !pwrite) begin
               prdata <= rd_d;
            end else begin
               prdata <= 32'h00000000;
            end
         end
         if (access && pwrite && in_range && is_ctrl && pstrb[0]) begin
            large_q <= pwdata[0];
         end
         if (access && !pwrite && in_range && is_tbl) begin
            last_q <= word_addr;
         end
      end
   end

endmodule

// ===== verif/sfdp_host.sv
// APB host model that reads the parameter store.
`timescale 1ns/1ps
module sfdp_host (
   input wire pclk,
   input wire pready,
   output logic psel = 1'b0,
   output logic penable = 1'b0,
   output logic pwrite = 1'b0,
   output logic [31:0] paddr = 32'h0,
   output logic [31:0] pwdata = 32'h0,
   output logic [3:0] pstrb = 4'h0
);
   // ----
   // One transfer, entered just after a rising edge.
   // ----
   task automatic xfer(input logic w, input logic [31:0] a, d, input logic [3:0] s);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
      // Released address and data lines carry the inverse so stale values cannot pass.
      paddr <= ~a;
      pwdata <= ~d;
      @(posedge pclk);
   endtask
endmodule

// ===== verif/sfdp_assertions.sv
// Port checker for the parameter store.
`timescale 1ns/1ps
module sfdp_chk (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   input wire pready,
   input wire [31:0] prdata,
   input wire pslverr,
   input wire large_block_mode
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire acc = psel && penable;
   wire rd = acc && !pwrite;
   a_byte30_word: assert property (rd && paddr == 32'h30 |-> prdata == 32'hFFFB20E5)
      else $error("word 30 wrong");
   a_density_word: assert property (rd && paddr == 32'h34 |-> prdata == 32'h1FFFFFFF)
      else $error("density wrong");
   a_quad_word: assert property (rd && paddr == 32'h38 |-> prdata == 32'h6B08EB44)
      else $error("word 38 wrong");
   a_wide_word: assert property (rd && paddr == 32'h40 |-> prdata == 32'hFFFFFFFE)
      else $error("word 40 wrong");
   a_erase_variant: assert property (rd && paddr == 32'h50 |->
      prdata == (large_block_mode ? 32'hD812FF00 : 32'hFF00D810)) else $error("erase types wrong");
   a_time_variant: assert property (rd && paddr == 32'h54 |->
      prdata == (large_block_mode ? 32'h4A014262 : 32'h00A94262)) else $error("times wrong");
   a_hdr_pointer: assert property (rd && paddr == 32'h0C |-> prdata == 32'hFF000030)
      else $error("pointer wrong");
   a_refused_hold: assert property (acc && pslverr |=> $stable(large_block_mode))
      else $error("refused write took effect");
   a_ctrl_take: assert property (acc && pwrite && paddr == 32'hF0 && pstrb[0] |=>
      large_block_mode == $past(pwdata[0])) else $error("variant not taken");
   c_large_read: cover property (rd && paddr == 32'h50 && large_block_mode);
   c_refused: cover property (acc && pslverr);
   c_ctrl_write: cover property (acc && pwrite && paddr == 32'hF0);
endmodule
bind sfdp_basic_param_rom sfdp_chk i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .pwdata, .pstrb, .pready, .prdata, .pslverr, .large_block_mode);

// ===== verif/sfdp_basic_param_rom_test.sv
// Self-checking bench for the parameter store.
`timescale 1ns/1ps
module sfdp_basic_param_rom_test;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   wire psel, penable, pwrite, pready, pslverr, large_block_mode;
   wire [31:0] paddr, pwdata, prdata;
   wire [3:0] pstrb;
   logic [33:0] exp_q[$];
   logic [33:0] e;
   logic [31:0] d;
   logic lg = 1'b0;
   logic [7:0] last_t = 8'h00;
   int miscompares = 0;
   int comparisons = 0;
   int cycles = 0;
   int i;
   always #2 pclk = ~pclk;
   sfdp_basic_param_rom i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pstrb, .pready, .prdata, .pslverr, .large_block_mode);
   sfdp_host i_host (.pclk, .pready, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb);
   task automatic check(input logic [31:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic logic [31:0] word(input logic [31:0] ad, input logic l);
      case (ad)
         32'h0C: word = 32'hFF000030;
         32'h30: word = 32'hFFFB20E5;
         32'h34: word = 32'h1FFFFFFF;
         32'h38: word = 32'h6B08EB44;
         32'h3C: word = 32'hBB803B08;
         32'h40: word = 32'hFFFFFFFE;
         32'h44: word = 32'hFF00FFFF;
         32'h48: word = 32'hEB44FFFF;
         32'h4C: word = 32'h520F200C;
         32'h50: word = l ? 32'hD812FF00 : 32'hFF00D810;
         32'hF0: word = {31'h0, l};
         default: word = l ? 32'h4A014262 : 32'h00A94262;
      endcase
   endfunction
   task automatic rd(input logic [31:0] ad, input logic err);
      exp_q.push_back({1'b1, err, err ? 32'h0 :
         (ad == 32'hF4) ? {16'h0, last_t, 7'h0, lg} : word(ad, lg)});
      if (!err && ad >= 32'h30 && ad <= 32'h54) last_t = ad[7:0];
      i_host.xfer(1'b0, ad, 32'h0, 4'hF);
   endtask
   task automatic wr(input logic [31:0] ad, dt, input logic [3:0] s, input logic err);
      exp_q.push_back({1'b0, err, 32'h0});
      i_host.xfer(1'b1, ad, dt, s);
   endtask
   task automatic finish_test;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         finish_test();
      end else if (psel && penable && pready === 1'b1) begin
         e = exp_q.pop_front();
         check({31'h0, pslverr}, {31'h0, e[32]});
         if (e[33]) check(prdata, e[31:0]);
      end
   end
   initial begin
      void'($urandom(32'h1EF5));
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (i = 0; i < 10; i++) rd(32'h30 + 4 * i, 1'b0);
      rd(32'h0C, 1'b0);
      // ----
      // Refused accesses and a control write without byte-0 strobe leave the variant alone.
      // ----
      wr(32'h30, 32'h1, 4'hF, 1'b1);
      wr(32'h0C, 32'h1, 4'hF, 1'b1);
      rd(32'h80, 1'b1);
      rd(32'h31, 1'b1);
      rd(32'h130, 1'b1);
      wr(32'hF0, 32'h1, 4'hE, 1'b0);
      check({31'h0, large_block_mode}, {31'h0, lg});
      for (i = 0; i < 40; i++) begin
         d = $urandom;
         if (d[7:6] == 2'b00) begin
            wr(32'hF0, d, 4'hF, 1'b0);
            lg = d[0];
            check({31'h0, large_block_mode}, {31'h0, lg});
         end else
            rd(32'h30 + 4 * (d[15:8] % 10), 1'b0);
      end
      wr(32'hF0, 32'h1, 4'hF, 1'b0);
      lg = 1'b1;
      rd(32'h50, 1'b0);
      rd(32'h54, 1'b0);
      wr(32'hF4, 32'h0, 4'hF, 1'b1);
      rd(32'hF0, 1'b0);
      rd(32'hF4, 1'b0);
      // Reset in mid-run returns the store to the standard variant.
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      lg = 1'b0;
      last_t = 8'h00;
      check({31'h0, large_block_mode}, {31'h0, lg});
      presetn <= 1'b1;
      @(posedge pclk);
      rd(32'hF4, 1'b0);
      rd(32'hF0, 1'b0);
      rd(32'h50, 1'b0);
      rd(32'h54, 1'b0);
      finish_test();
   end
endmodule
